// ==== logic/port_b_alternate_pin_mux.v ====
// port b alternate function override logic with wishbone control registers
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "port_b_mux_regs.vh"

module port_b_alternate_pin_mux (
    input  wire       clk_i,
    input  wire       rst_i,
    // wishbone slave
    input  wire       cyc_i,
    input  wire       stb_i,
    input  wire       we_i,
    input  wire [3:0] adr_i,
    input  wire [3:0] sel_i,
    input  wire [31:0] dat_i,
    output wire [31:0] dat_o,
    output wire       ack_o,
    // peripheral side
    input  wire       timer0_compare_a_en_i,
    input  wire       timer0_compare_a_out_i,
    input  wire       timer1_compare_a_en_i,
    input  wire       timer1_compare_a_out_i,
    input  wire       timer1_compare_b_en_i,
    input  wire       timer1_compare_b_out_i,
    input  wire       timer1_compare_c_en_i,
    input  wire       timer1_compare_c_out_i,
    input  wire       timer4_compare_b_en_i,
    input  wire       timer4_compare_b_out_i,
    input  wire       uart_rts_i,
    input  wire       spi_enable_i,
    input  wire       spi_master_i,
    input  wire       spi_master_out_i,
    input  wire       spi_slave_out_i,
    input  wire       spi_sck_out_i,
    output wire       spi_master_in_o,
    output wire       spi_slave_in_o,
    output wire       spi_sck_in_o,
    output wire       spi_ss_in_o,
    input  wire       prog_mode_i,
    input  wire       prog_data_out_i,
    output wire       prog_data_in_o,
    output wire [7:1] pin_change_src_o,
    output wire       debug_port_disable_o,
    output wire       vector_table_select_o,
    output wire       vector_change_enable_o,
    // pads
    input  wire [7:0] pad_i,
    output wire [7:0] pad_o,
    output wire [7:0] pad_oe_o,
    output wire [7:0] pad_pullup_o
);

    // ------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------
    reg  [7:0]  mcu_control_r;
    reg  [7:0]  portb_dir_r;
    reg  [7:0]  portb_latch_r;
    reg  [7:0]  alt_select_r;
    reg         ack_r;
    reg  [31:0] dat_r;
    reg  [7:0]  rd_nxt;
    wire        req = cyc_i & stb_i & ~ack_r;
    wire        wr  = req & we_i & sel_i[0];
    wire        global_pullup_disable = mcu_control_r[`MCU_PUD_BIT];

    always @* begin
        case (adr_i)
            `MCU_CONTROL_ADDR: rd_nxt = mcu_control_r;
            `PORTB_DIR_ADDR:   rd_nxt = portb_dir_r;
            `PORTB_LATCH_ADDR: rd_nxt = portb_latch_r;
            `PORTB_PIN_ADDR:   rd_nxt = pad_i;
            default:           rd_nxt = 8'h00;
        endcase
    end

    always @(posedge clk_i) begin
        if (rst_i) begin
            mcu_control_r <= `MCU_CONTROL_RESET;
            portb_dir_r   <= `PORTB_RESET;
            portb_latch_r <= `PORTB_RESET;
            ack_r         <= 1'b0;
            dat_r         <= 32'h0000_0000;
        end else begin
            ack_r <= req;
            if (req)
                dat_r <= {24'h00_0000, rd_nxt};
            if (wr) begin
                case (adr_i)
                    `MCU_CONTROL_ADDR: mcu_control_r <= dat_i[7:0] & `MCU_CONTROL_WMASK;
                    `PORTB_DIR_ADDR:   portb_dir_r   <= dat_i[7:0];
                    `PORTB_LATCH_ADDR: portb_latch_r <= dat_i[7:0];
                    default:           mcu_control_r <= mcu_control_r;
                endcase
            end
        end
    end

    // alt select bits come from bits 15:8 of the latch-register word
    always @(posedge clk_i) begin
        if (rst_i)
            alt_select_r <= `ALT_SELECT_RESET;
        else if (req & we_i & sel_i[1] & (adr_i == `PORTB_LATCH_ADDR))
            alt_select_r <= dat_i[15:8];
    end

    assign ack_o = ack_r;
    assign dat_o = ack_r ? (dat_r | ((adr_i == `PORTB_LATCH_ADDR) ?
                           {16'h0000, alt_select_r, 8'h00} : 32'h0000_0000)) : 32'h0000_0000;

    assign debug_port_disable_o   = mcu_control_r[`MCU_DBG_DIS_BIT];
    assign vector_table_select_o  = mcu_control_r[`MCU_VEC_SEL_BIT];
    assign vector_change_enable_o = mcu_control_r[`MCU_VEC_CHG_BIT];

    // ------------------------------------------------------------
    // override signals per pin
    // ------------------------------------------------------------
    reg [7:0] pullup_override_enable;
    reg [7:0] pullup_override_value;
    reg [7:0] direction_override_enable;
    reg [7:0] direction_override_value;
    reg [7:0] value_override_enable;
    reg [7:0] value_override_value;
    wire spi_mst = spi_enable_i & spi_master_i;
    wire spi_slv = spi_enable_i & ~spi_master_i;

    always @* begin
        pullup_override_enable    = 8'h00;
        pullup_override_value     = 8'h00;
        direction_override_enable = 8'h00;
        direction_override_value  = 8'h00;
        value_override_enable     = 8'h00;
        value_override_value      = 8'h00;
        // bit 7: fixed priority timer0, then timer1 c, then rts
        if (timer0_compare_a_en_i) begin
            value_override_enable[7] = 1'b1;
            value_override_value[7]  = timer0_compare_a_out_i;
        end else if (timer1_compare_c_en_i) begin
            value_override_enable[7] = 1'b1;
            value_override_value[7]  = timer1_compare_c_out_i;
        end else if (alt_select_r[`ALT_B7_RTS_BIT]) begin
            value_override_enable[7] = 1'b1;
            value_override_value[7]  = uart_rts_i;
        end
        if (timer1_compare_b_en_i) begin
            value_override_enable[6] = 1'b1;
            value_override_value[6]  = timer1_compare_b_out_i;
        end else if (timer4_compare_b_en_i & alt_select_r[`ALT_B6_T4_BIT]) begin
            value_override_enable[6] = 1'b1;
            value_override_value[6]  = timer4_compare_b_out_i;
        end
        if (timer1_compare_a_en_i) begin
            value_override_enable[5] = 1'b1;
            value_override_value[5]  = timer1_compare_a_out_i;
        end else if (timer4_compare_b_en_i & alt_select_r[`ALT_B5_T4_BIT]) begin
            value_override_enable[5] = 1'b1;
            value_override_value[5]  = ~timer4_compare_b_out_i;
        end
        // spi: master forces bit 3 in, slave forces bits 2..0 in
        if (spi_mst) begin
            direction_override_enable[3] = 1'b1;
            pullup_override_enable[3]    = 1'b1;
            pullup_override_value[3]     = portb_latch_r[3] & ~global_pullup_disable;
            value_override_enable[2:1]   = 2'b11;
            value_override_value[2]      = spi_master_out_i;
            value_override_value[1]      = spi_sck_out_i;
        end
        if (spi_slv) begin
            direction_override_enable[2:0] = 3'b111;
            pullup_override_enable[2:0]    = 3'b111;
            pullup_override_value[2:0]     = portb_latch_r[2:0] &
                                             {3{~global_pullup_disable}};
            value_override_enable[3]       = 1'b1;
            value_override_value[3]        = spi_slave_out_i;
        end
        // serial programming owns bits 3 and 2
        if (prog_mode_i) begin
            direction_override_enable[3:2] = 2'b11;
            direction_override_value[3:2]  = 2'b10;
            value_override_enable[3]       = 1'b1;
            value_override_value[3]        = prog_data_out_i;
            pullup_override_enable[3:2]    = 2'b11;
            pullup_override_value[3:2]     = 2'b00;
        end
    end

    // ------------------------------------------------------------
    // pad drive
    // ------------------------------------------------------------
    port_b_pin_cell pin7_cell (
        .dir_i        (portb_dir_r[7]),              .latch_i      (portb_latch_r[7]),
        .pud_i        (global_pullup_disable),       .pu_ovr_en_i  (pullup_override_enable[7]),
        .pu_ovr_val_i (pullup_override_value[7]),    .dir_ovr_en_i (direction_override_enable[7]),
        .dir_ovr_val_i(direction_override_value[7]), .val_ovr_en_i (value_override_enable[7]),
        .val_ovr_val_i(value_override_value[7]),     .pad_o        (pad_o[7]),
        .pad_oe_o     (pad_oe_o[7]),                 .pad_pullup_o (pad_pullup_o[7])
    );

    port_b_pin_cell pin6_cell (
        .dir_i        (portb_dir_r[6]),              .latch_i      (portb_latch_r[6]),
        .pud_i        (global_pullup_disable),       .pu_ovr_en_i  (pullup_override_enable[6]),
        .pu_ovr_val_i (pullup_override_value[6]),    .dir_ovr_en_i (direction_override_enable[6]),
        .dir_ovr_val_i(direction_override_value[6]), .val_ovr_en_i (value_override_enable[6]),
        .val_ovr_val_i(value_override_value[6]),     .pad_o        (pad_o[6]),
        .pad_oe_o     (pad_oe_o[6]),                 .pad_pullup_o (pad_pullup_o[6])
    );

    port_b_pin_cell pin5_cell (
        .dir_i        (portb_dir_r[5]),              .latch_i      (portb_latch_r[5]),
        .pud_i        (global_pullup_disable),       .pu_ovr_en_i  (pullup_override_enable[5]),
        .pu_ovr_val_i (pullup_override_value[5]),    .dir_ovr_en_i (direction_override_enable[5]),
        .dir_ovr_val_i(direction_override_value[5]), .val_ovr_en_i (value_override_enable[5]),
        .val_ovr_val_i(value_override_value[5]),     .pad_o        (pad_o[5]),
        .pad_oe_o     (pad_oe_o[5]),                 .pad_pullup_o (pad_pullup_o[5])
    );

    port_b_pin_cell pin4_cell (
        .dir_i        (portb_dir_r[4]),              .latch_i      (portb_latch_r[4]),
        .pud_i        (global_pullup_disable),       .pu_ovr_en_i  (pullup_override_enable[4]),
        .pu_ovr_val_i (pullup_override_value[4]),    .dir_ovr_en_i (direction_override_enable[4]),
        .dir_ovr_val_i(direction_override_value[4]), .val_ovr_en_i (value_override_enable[4]),
        .val_ovr_val_i(value_override_value[4]),     .pad_o        (pad_o[4]),
        .pad_oe_o     (pad_oe_o[4]),                 .pad_pullup_o (pad_pullup_o[4])
    );

    port_b_pin_cell pin3_cell (
        .dir_i        (portb_dir_r[3]),              .latch_i      (portb_latch_r[3]),
        .pud_i        (global_pullup_disable),       .pu_ovr_en_i  (pullup_override_enable[3]),
        .pu_ovr_val_i (pullup_override_value[3]),    .dir_ovr_en_i (direction_override_enable[3]),
        .dir_ovr_val_i(direction_override_value[3]), .val_ovr_en_i (value_override_enable[3]),
        .val_ovr_val_i(value_override_value[3]),     .pad_o        (pad_o[3]),
        .pad_oe_o     (pad_oe_o[3]),                 .pad_pullup_o (pad_pullup_o[3])
    );

    port_b_pin_cell pin2_cell (
        .dir_i        (portb_dir_r[2]),              .latch_i      (portb_latch_r[2]),
        .pud_i        (global_pullup_disable),       .pu_ovr_en_i  (pullup_override_enable[2]),
        .pu_ovr_val_i (pullup_override_value[2]),    .dir_ovr_en_i (direction_override_enable[2]),
        .dir_ovr_val_i(direction_override_value[2]), .val_ovr_en_i (value_override_enable[2]),
        .val_ovr_val_i(value_override_value[2]),     .pad_o        (pad_o[2]),
        .pad_oe_o     (pad_oe_o[2]),                 .pad_pullup_o (pad_pullup_o[2])
    );

    port_b_pin_cell pin1_cell (
        .dir_i        (portb_dir_r[1]),              .latch_i      (portb_latch_r[1]),
        .pud_i        (global_pullup_disable),       .pu_ovr_en_i  (pullup_override_enable[1]),
        .pu_ovr_val_i (pullup_override_value[1]),    .dir_ovr_en_i (direction_override_enable[1]),
        .dir_ovr_val_i(direction_override_value[1]), .val_ovr_en_i (value_override_enable[1]),
        .val_ovr_val_i(value_override_value[1]),     .pad_o        (pad_o[1]),
        .pad_oe_o     (pad_oe_o[1]),                 .pad_pullup_o (pad_pullup_o[1])
    );

    port_b_pin_cell pin0_cell (
        .dir_i        (portb_dir_r[0]),              .latch_i      (portb_latch_r[0]),
        .pud_i        (global_pullup_disable),       .pu_ovr_en_i  (pullup_override_enable[0]),
        .pu_ovr_val_i (pullup_override_value[0]),    .dir_ovr_en_i (direction_override_enable[0]),
        .dir_ovr_val_i(direction_override_value[0]), .val_ovr_en_i (value_override_enable[0]),
        .val_ovr_val_i(value_override_value[0]),     .pad_o        (pad_o[0]),
        .pad_oe_o     (pad_oe_o[0]),                 .pad_pullup_o (pad_pullup_o[0])
    );

    assign spi_master_in_o  = pad_i[3];
    assign spi_slave_in_o   = pad_i[2];
    assign spi_sck_in_o     = pad_i[1];
    assign spi_ss_in_o      = pad_i[0];
    assign prog_data_in_o   = pad_i[2];
    assign pin_change_src_o = pad_i[7:1];

endmodule // port_b_alternate_pin_mux

// ------------------------------------------------------------
// one pad: resolves drive enable, drive value and pull-up
// ------------------------------------------------------------
module port_b_pin_cell (
    input  wire dir_i,
    input  wire latch_i,
    input  wire pud_i,
    input  wire pu_ovr_en_i,
    input  wire pu_ovr_val_i,
    input  wire dir_ovr_en_i,
    input  wire dir_ovr_val_i,
    input  wire val_ovr_en_i,
    input  wire val_ovr_val_i,
    output wire pad_o,
    output wire pad_oe_o,
    output wire pad_pullup_o
);
    wire drive_en     = dir_ovr_en_i ? dir_ovr_val_i : dir_i;
    wire plain_pullup = ~dir_i & latch_i & ~pud_i;

    assign pad_oe_o     = drive_en;
    assign pad_o        = val_ovr_en_i ? val_ovr_val_i : latch_i;
    // global disable beats an alternate function's pull-up request too
    assign pad_pullup_o = (pu_ovr_en_i ? pu_ovr_val_i : plain_pullup) &
                          ~drive_en & ~pud_i;
endmodule // port_b_pin_cell

// ==== logic/port_b_mux_regs.vh ====
// constants for the port b alternate pin mux and its control register
`ifndef PORT_B_MUX_REGS_VH
`define PORT_B_MUX_REGS_VH

`define MCU_CONTROL_ADDR        4'h0
`define PORTB_DIR_ADDR          4'h4
`define PORTB_LATCH_ADDR        4'h8
`define PORTB_PIN_ADDR          4'hc
`define ALT_SELECT_ADDR         4'h0
`define MCU_CONTROL_RESET       8'h00
`define MCU_CONTROL_WMASK       8'h93
`define PORTB_RESET             8'h00
`define ALT_SELECT_RESET        8'h00
`define MCU_PUD_BIT             4
`define MCU_DBG_DIS_BIT         7
`define MCU_VEC_SEL_BIT         1
`define MCU_VEC_CHG_BIT         0
`define ALT_B7_RTS_BIT          0
`define ALT_B6_T4_BIT           1
`define ALT_B5_T4_BIT           2

`endif

// ==== testbench/port_b_mux_chk.sv ====
// assertions on the port b pin mux ports
`timescale 1ns/1ps
module port_b_mux_chk (
    input logic        clk_i,
    input logic        rst_i,
    input logic        cyc_i,
    input logic        stb_i,
    input logic        we_i,
    input logic [3:0]  adr_i,
    input logic [3:0]  sel_i,
    input logic [31:0] dat_i,
    input logic [31:0] dat_o,
    input logic        ack_o,
    input logic        timer0_compare_a_en_i,
    input logic        timer0_compare_a_out_i,
    input logic        spi_enable_i,
    input logic        spi_master_i,
    input logic        prog_mode_i,
    input logic        prog_data_out_i,
    input logic        prog_data_in_o,
    input logic [7:1]  pin_change_src_o,
    input logic [7:0]  pad_i,
    input logic [7:0]  pad_o,
    input logic [7:0]  pad_oe_o,
    input logic [7:0]  pad_pullup_o
);
    default clocking dc @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic pud_r;
    // shadow pull-up disable; write lands on the taken edge
    always_ff @(posedge clk_i)
        if (rst_i)
            pud_r <= 1'b0;
        else if (cyc_i && stb_i && we_i && !ack_o && adr_i == 4'h0 && sel_i[0])
            pud_r <= dat_i[4];
    // ----
    // checks
    // ----
    sequence taken_s; cyc_i && stb_i && !ack_o; endsequence
    sequence answer_s; ack_o ##1 !ack_o; endsequence
    chk_ack_follows: assert property (taken_s |=> answer_s) else $error("bad ack");
    chk_idle_data: assert property (!ack_o |-> dat_o == 32'h0) else $error("bad idle data");
    chk_pud_gate: assert property (pud_r |-> pad_pullup_o == 8'h00)
        else $error("pull-up on");
    chk_pin_change: assert property (pin_change_src_o == pad_i[7:1])
        else $error("pc src");
    chk_prog_out: assert property (
        prog_mode_i |-> pad_oe_o[3] && pad_o[3] == prog_data_out_i) else $error("prog out");
    chk_prog_in: assert property (
        prog_mode_i |-> !pad_oe_o[2] && prog_data_in_o == pad_i[2]) else $error("prog in");
    chk_miso_input: assert property (
        spi_enable_i && spi_master_i && !prog_mode_i |-> !pad_oe_o[3]) else $error("miso driven");
    chk_slave_inputs: assert property (
        spi_enable_i && !spi_master_i |-> pad_oe_o[2:0] == 3'h0) else $error("slave pin driven");
    chk_timer0_first: assert property (timer0_compare_a_en_i && pad_oe_o[7] |->
        pad_o[7] == timer0_compare_a_out_i) else $error("timer0 lost");
endmodule // port_b_mux_chk

bind port_b_alternate_pin_mux port_b_mux_chk port_b_mux_chk_i (.clk_i, .rst_i, .cyc_i, .stb_i,
    .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .timer0_compare_a_en_i, .timer0_compare_a_out_i,
    .spi_enable_i, .spi_master_i, .prog_mode_i, .prog_data_out_i, .prog_data_in_o,
    .pin_change_src_o, .pad_i, .pad_o, .pad_oe_o, .pad_pullup_o);

// ==== testbench/pad_model.sv ====
// pins and board: driver, else pull-up, else what the board presents
`timescale 1ns/1ps
module pad_model (
    input  logic [7:0] drv_i,
    input  logic [7:0] oe_i,
    input  logic [7:0] pu_i,
    input  logic [7:0] ext_i,
    output logic [7:0] level_o
);
    always_comb
        for (int b = 0; b < 8; b++)
            level_o[b] = oe_i[b] ? drv_i[b] : (pu_i[b] ? 1'b1 : ext_i[b]);
endmodule // pad_model

// ==== testbench/tb_port_b_alternate_pin_mux.sv ====
// self-checking bench for the port b pin mux
`timescale 1ns/1ps
module tb_port_b_alternate_pin_mux;
    logic        clk_i, rst_i, cyc, stb, we, pud_m, prog_data_in;
    logic [3:0]  adr, sel, spi_in;
    logic [31:0] wdat, rdat, dat_o, e, g;
    logic        ack_o;
    logic [17:0] per;
    logic [7:0]  ext, pad_i, pad_o, pad_oe_o, pad_pullup_o, dir_m, lat_m, alt_m;
    logic [6:0]  pcs;
    logic [2:0]  mcu_bits;
    integer      err_count, samples_checked, seed, cycles, i;
    port_b_alternate_pin_mux port_b_alternate_pin_mux_i (.clk_i, .rst_i, .cyc_i(cyc), .stb_i(stb),
        .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(wdat), .dat_o, .ack_o,
        .timer0_compare_a_en_i(per[0]), .timer0_compare_a_out_i(per[1]),
        .timer1_compare_a_en_i(per[2]), .timer1_compare_a_out_i(per[3]),
        .timer1_compare_b_en_i(per[4]), .timer1_compare_b_out_i(per[5]),
        .timer1_compare_c_en_i(per[6]), .timer1_compare_c_out_i(per[7]),
        .timer4_compare_b_en_i(per[8]), .timer4_compare_b_out_i(per[9]), .uart_rts_i(per[10]),
        .spi_enable_i(per[11]), .spi_master_i(per[12]), .spi_master_out_i(per[13]),
        .spi_slave_out_i(per[14]), .spi_sck_out_i(per[15]), .spi_master_in_o(spi_in[3]),
        .spi_slave_in_o(spi_in[2]), .spi_sck_in_o(spi_in[1]), .spi_ss_in_o(spi_in[0]),
        .prog_mode_i(per[16]), .prog_data_out_i(per[17]), .prog_data_in_o(prog_data_in),
        .pin_change_src_o(pcs), .debug_port_disable_o(mcu_bits[2]),
        .vector_table_select_o(mcu_bits[1]), .vector_change_enable_o(mcu_bits[0]),
        .pad_i, .pad_o, .pad_oe_o, .pad_pullup_o);
    pad_model pad_model_i (.drv_i(pad_o), .oe_i(pad_oe_o), .pu_i(pad_pullup_o), .ext_i(ext),
        .level_o(pad_i));
    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    // ----
    // expectation: {value mask, drive, value, pull-up}
    // ----
    function automatic logic [31:0] exp_pads();
        logic [7:0] oe, o, pu, m;
        oe = dir_m;
        o = lat_m;
        pu = ~dir_m & lat_m & {8{~pud_m}};
        m = 8'hff;
        if (per[0]) o[7] = per[1];
        else if (per[6]) o[7] = per[7];
        else if (alt_m[0]) o[7] = per[10];
        if (per[4]) o[6] = per[5];
        else if (per[8] & alt_m[1]) o[6] = per[9];
        if (per[2]) o[5] = per[3];
        else if (per[8] & alt_m[2]) o[5] = ~per[9];
        if (per[11]) begin
            if (per[12]) begin
                oe[3] = 1'b0;
                pu[3] = lat_m[3] & ~pud_m;
                o[2:1] = {per[13], per[15]};
            end else begin
                oe[2:0] = 3'h0;
                pu[2:0] = lat_m[2:0] & {3{~pud_m}};
                o[3] = per[14];
            end
        end
        if (per[16]) begin
            oe[3:2] = 2'h2;
            o[3] = per[17];
            m[3] = 1'b1;
            pu[3:2] = 2'h0;
        end
        m = m & oe;
        return {m, oe, o & m, pu};
    endfunction
    task automatic cmp(input string name, input logic [31:0] ev, input logic [31:0] gv);
        samples_checked++;
        if (gv !== ev) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", name, ev, gv);
        end
    endtask
    // called just after a rising edge; request held until the edge that samples ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [3:0] s,
                      input logic [31:0] d);
        integer n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        @(posedge clk_i);
        while (ack_o !== 1'b1 && n < 20) begin
            @(posedge clk_i);
            n++;
        end
        if (n == 20) err_count++;
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            err_count++;
            end_sim();
        end
    end
    initial begin
        {seed, err_count, samples_checked, cycles, rst_i} = {32'd8, 96'd0, 1'b1};
        {cyc, stb, we, adr, sel, wdat, per, ext} = '0;
        {dir_m, lat_m, alt_m, pud_m} = '0;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        for (i = 0; i < 16; i += 4) begin
            wb(1'b0, 4'(i), 4'hf, 32'h0);
            cmp("reset value", 32'h0, rdat);
        end
        wb(1'b1, 4'h0, 4'h1, 32'hff);
        wb(1'b0, 4'h0, 4'hf, 32'h0);
        cmp("control", 32'h93, rdat);
        cmp("control bits", 32'h7, {29'h0, mcu_bits});
        wb(1'b1, 4'h2, 4'hf, 32'hff);
        wb(1'b0, 4'h2, 4'hf, 32'h0);
        cmp("unmapped", 32'h0, rdat);
        $display("register test done");
        for (i = 0; i < 300; i++) begin
            dir_m = 8'($random(seed));
            lat_m = 8'($random(seed));
            alt_m = 8'($random(seed)) & 8'h07;
            pud_m = 1'($random(seed));
            // corner: every pin asks for a pull-up, with and without the global disable
            if (i < 2) {dir_m, lat_m, pud_m} = {16'h00ff, ~i[0]};
            per <= 18'($random(seed));
            ext <= 8'($random(seed));
            wb(1'b1, 4'h4, 4'h1, {24'h0, dir_m});
            wb(1'b1, 4'h8, 4'h3, {16'h0, alt_m, lat_m});
            wb(1'b1, 4'h0, 4'h1, {27'h0, pud_m, 4'h0});
            @(negedge clk_i);
            e = exp_pads();
            g = {8'h0, pad_oe_o, pad_o & e[31:24], pad_pullup_o};
            cmp("pads", {8'h0, e[23:0]}, g);
            g = {20'h0, pcs, prog_data_in, spi_in};
            cmp("pad inputs", {20'h0, pad_i[7:1], pad_i[2], pad_i[3:0]}, g);
            @(posedge clk_i);
            wb(1'b0, 4'h8, 4'hf, 32'h0);
            cmp("latch", {16'h0, alt_m, lat_m}, rdat & 32'h07ff);
            wb(1'b0, 4'hc, 4'hf, 32'h0);
            cmp("pin read", {24'h0, pad_i}, rdat);
        end
        $display("random test done");
        end_sim();
    end
endmodule // tb_port_b_alternate_pin_mux
